// *** disp_pkg.sv ***
// Shared constants and types for the serial dot-matrix display controller.
// Assumes a 25 MHz system clock and one controller per display.
package disp_pkg;

   // System clock and the internal multiplex oscillator it emulates.
   localparam int MCLK_HZ = 25_000_000;
   localparam int OSC_HZ = 240_000;
   localparam int OSC_HALF_CYCLES = MCLK_HZ / (2 * OSC_HZ);
   localparam logic [7:0] OSC_HALF_RST = 8'(OSC_HALF_CYCLES);

   // Display geometry.
   localparam int NUM_CHARS = 10;
   localparam int NUM_ROWS = 5;
   localparam int NUM_COLS = 5;
   localparam int COL_BITS = NUM_CHARS * NUM_COLS;
   localparam logic [COL_BITS-1:0] ALL_COLS = {COL_BITS{1'b1}};

   // Row multiplexer: a 320-step phase counter per row.
   localparam logic [8:0] MUX_LAST = 9'h13F;
   localparam logic [2:0] ROW_LAST = 3'h4;
   localparam logic [4:0] ROW_ONE = 5'h01;

   // Opcodes and control words.
   localparam logic [2:0] OP_ROW_LAST = 3'h4;
   localparam logic [2:0] OP_ADDR = 3'h5;
   localparam logic [2:0] OP_CTRL = 3'h7;
   localparam int ADDR_FLAG_BIT = 4;
   localparam logic [3:0] CHAR_MAX = 4'h9;
   localparam logic [4:0] CW_LEVEL_MIN = 5'h10;
   localparam logic [4:0] CW_LEVEL_MAX = 5'h16;
   localparam logic [4:0] CW_LAMP = 5'h18;
   localparam logic [4:0] CW_PDOWN = 5'h1F;
   localparam logic [7:0] WORD_CLEAR = 8'hC0;

   // Strobe on-time in phase steps per level: 100, 53, 40, 27, 20, 13, 6.6 %.
   localparam logic [6:0][8:0] DUTY_TBL = {9'h015, 9'h02A, 9'h040, 9'h056,
                                           9'h080, 9'h0AA, 9'h140};
   localparam logic [2:0] LEVEL_FULL = 3'h0;
   localparam logic [2:0] LEVEL_LAMP = 3'h1;

   // Wishbone register map.
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_STAT = 8'h04;
   localparam logic [7:0] REG_OSC = 8'h08;

   typedef struct packed {
      logic [2:0] op;
      logic [4:0] pl;
   } cmd_word_t;

   typedef struct packed {
      logic en;
      logic [2:0] row;
      logic [3:0] chr;
      logic [4:0] data;
   } ram_wr_t;

   typedef struct packed {
      logic sck;
      logic sdata;
      logic load_n;
      logic rst_n;
      logic sel;
      logic clk_in;
   } pin_sync_t;
   localparam pin_sync_t PIN_RST = 6'h1E;

   typedef struct packed {
      logic [18:0] zero;
      logic [2:0] row;
      logic clr;
      logic pdown;
      logic lamp;
      logic [2:0] level;
      logic [3:0] addr;
   } stat_t;

endpackage

// *** dual_flop_sync.sv ***
// Two-flop synchroniser for a group of asynchronous pin levels.
// Assumes the pins change slowly compared with mclk.
`timescale 1ns/100ps
module dual_flop_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic srst,
   // Asynchronous levels in, synchronised levels out.
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_ff;

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         meta_ff <= RST_VAL;
         q <= RST_VAL;
      end
      else
      begin
         meta_ff <= d;
         q <= meta_ff;
      end
   end
endmodule // dual_flop_sync

// *** display_ram.sv ***
// Display memory: five row words, each holding five columns for ten chars.
// Assumes one writer; a clear wins over a write in the same cycle.
`timescale 1ns/100ps
module display_ram (
   // Clock and reset.
   input wire logic mclk,
   input wire logic srst,
   // Write and clear.
   input disp_pkg::ram_wr_t wr,
   input wire logic clr,
   // Registered read of one whole row.
   input wire logic [2:0] rd_row,
   output logic [disp_pkg::COL_BITS-1:0] rd_data
);
   import disp_pkg::*;

   logic [COL_BITS-1:0] mem [NUM_ROWS];

   always_ff @(posedge mclk)
   begin
      if (srst || clr)
      begin
         for (int r = 0; r < NUM_ROWS; r++)
            mem[r] <= '0;
      end
      else if (wr.en)
         mem[wr.row][wr.chr*NUM_COLS +: NUM_COLS] <= wr.data;
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
         rd_data <= '0;
      else
         rd_data <= mem[rd_row];
   end

   a_ram_write: assert property (@(posedge mclk) disable iff (srst)
      wr.en && !clr |=> mem[$past(wr.row)][$past(wr.chr)*NUM_COLS +: NUM_COLS]
                        == $past(wr.data))
      else $error("Row data not stored at addressed character.");
endmodule // display_ram

// *** serial_dot_matrix_display_ctrl.sv ***
// Serial command decoder and row multiplexer for a ten-character 5x5 display.
// Assumes pins are asynchronous to mclk and a Wishbone master on mclk.
// What this block does
// - Word is opcode in bits 7..5 and five payload bits below.
// - While load is low, bits shift in LSB first on clock rise.
// - Load rising decodes the opcode and applies the payload.
// - Opcode 101 with bit 4 set loads character address 0..9.
// - Opcodes 000..100 write row 0..4 of addressed character, bit 4 column 0.
// - Words F0..F6 select brightness 100 down to 6.6 percent.
// - Brightness comes from row strobe duty, not column data.
// - Word FF powers down: display dark, multiplex clock halted.
// - Serial writes still land in RAM while powered down.
// - Any brightness word ends power-down.
// - Word F8 lights every LED at 53 percent.
// - Lamp test leaves RAM alone and ends on a brightness word.
// - Word C0 clears RAM, blanks display, address back to zero.
// - Software clear keeps multiplex counter and control settings.
// - Clear stays in force until the next input cycle begins.
// - All ten characters are row multiplexed from RAM.
// - Row strobe advances every 320 multiplex clock ticks.
// - Select low takes the multiplex clock from the shared pin.
// - Reset pin low clears address, control word and RAM, blanks.
// - After reset: character 0 and full brightness.
//
// Design decisions made here: the address map and the Wishbone register port.
`timescale 1ns/100ps
module serial_dot_matrix_display_ctrl (
   // Clock and reset.
   input wire logic mclk,
   input wire logic srst,
   // Serial link pins.
   input wire logic serial_shift_clock,
   input wire logic serial_data,
   input wire logic load_n,
   input wire logic display_reset_n,
   // Multiplex clock pins.
   input wire logic row_multiplex_clock_source_select,
   input wire logic row_multiplex_clock_in,
   output logic row_multiplex_clock_out,
   output logic row_multiplex_clock_oe,
   // LED drive.
   output logic [disp_pkg::NUM_ROWS-1:0] row_strobe,
   output logic [disp_pkg::COL_BITS-1:0] col_drive,
   // Wishbone slave.
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o
);
   import disp_pkg::*;

   pin_sync_t pin_raw, pin_s, pin_d_ff;
   logic sck_rise, load_rise, load_fall, ext_tick, hw_clr;
   logic [7:0] shift_ff;
   logic wb_req, bus_cmd, bus_go, exec;
   cmd_word_t cw, last_word_ff;
   logic is_row, is_addr, is_ctrl, is_level, is_lamp, is_pdown, is_clear;
   logic known;
   logic [3:0] addr_ff;
   logic [2:0] level_ff;
   logic lamp_ff, pdown_ff, clear_active_ff;
   ram_wr_t ram_wr;
   logic [COL_BITS-1:0] ram_rd;
   logic [7:0] osc_div_ff, osc_cnt_ff;
   logic osc_ff, osc_wrap, int_tick, mux_tick, oe_ff;
   logic [8:0] phase_ff, duty_now;
   logic [2:0] row_ff, row_d_ff;
   logic strobe_on;
   logic [NUM_ROWS-1:0] row_strobe_ff;
   logic [COL_BITS-1:0] col_drive_ff;
   stat_t stat;

   assign pin_raw = '{sck: serial_shift_clock, sdata: serial_data,
                      load_n: load_n, rst_n: display_reset_n,
                      sel: row_multiplex_clock_source_select,
                      clk_in: row_multiplex_clock_in};

   dual_flop_sync #(.W(6), .RST_VAL(PIN_RST)) u_sync (
      .mclk(mclk),
      .srst(srst),
      .d(pin_raw),
      .q(pin_s)
   );

   always_ff @(posedge mclk)
   begin
      if (srst)
         pin_d_ff <= PIN_RST;
      else
         pin_d_ff <= pin_s;
   end

   assign sck_rise = pin_s.sck & ~pin_d_ff.sck;
   assign load_rise = pin_s.load_n & ~pin_d_ff.load_n;
   assign load_fall = ~pin_s.load_n & pin_d_ff.load_n;
   assign ext_tick = pin_s.clk_in & ~pin_d_ff.clk_in;
   assign hw_clr = srst | ~pin_s.rst_n;

   always_ff @(posedge mclk)
   begin
      if (srst)
         shift_ff <= '0;
      else if (sck_rise && !pin_s.load_n)
         shift_ff <= {pin_s.sdata, shift_ff[7:1]};
   end

   // A bus command that meets a serial load waits one cycle for its ack.
   assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign bus_cmd = wb_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == REG_CMD);
   assign bus_go = bus_cmd & ~load_rise;
   assign exec = load_rise | bus_go;
   assign cw = load_rise ? cmd_word_t'(shift_ff) : cmd_word_t'(wb_dat_i[7:0]);

   always_comb
   begin
      is_row = exec && (cw.op <= OP_ROW_LAST);
      is_addr = exec && (cw.op == OP_ADDR) && cw.pl[ADDR_FLAG_BIT]
                && (cw.pl[3:0] <= CHAR_MAX);
      is_ctrl = exec && (cw.op == OP_CTRL);
      is_level = is_ctrl && (cw.pl >= CW_LEVEL_MIN)
                 && (cw.pl <= CW_LEVEL_MAX);
      is_lamp = is_ctrl && (cw.pl == CW_LAMP);
      is_pdown = is_ctrl && (cw.pl == CW_PDOWN);
      is_clear = exec && (cw == WORD_CLEAR);
      known = is_row | is_addr | is_level | is_lamp | is_pdown | is_clear;
   end

   always_ff @(posedge mclk)
   begin
      if (hw_clr)
         addr_ff <= '0;
      else if (is_clear)
         addr_ff <= '0;
      else if (is_addr)
         addr_ff <= cw.pl[3:0];
   end

   always_ff @(posedge mclk)
   begin
      if (hw_clr)
      begin
         level_ff <= LEVEL_FULL;
         lamp_ff <= 1'b0;
         pdown_ff <= 1'b0;
      end
      else if (is_level)
      begin
         level_ff <= cw.pl[2:0];
         lamp_ff <= 1'b0;
         pdown_ff <= 1'b0;
      end
      else if (is_lamp)
         lamp_ff <= 1'b1;
      else if (is_pdown)
         pdown_ff <= 1'b1;
   end

   // A new clear wins over the start of an input cycle in the same edge.
   always_ff @(posedge mclk)
   begin
      if (hw_clr)
         clear_active_ff <= 1'b0;
      else if (is_clear)
         clear_active_ff <= 1'b1;
      else if (load_fall || bus_go)
         clear_active_ff <= 1'b0;
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
         last_word_ff <= '0;
      else if (exec)
         last_word_ff <= cw;
   end

   // Row writes are not gated by power-down.
   assign ram_wr = '{en: is_row, row: cw.op, chr: addr_ff,
                     data: cw.pl};

   display_ram u_ram (
      .mclk(mclk),
      .srst(srst),
      .wr(ram_wr),
      .clr(hw_clr | is_clear),
      .rd_row(row_ff),
      .rd_data(ram_rd)
   );

   // Internal oscillator; it stops in power-down to save the toggling.
   assign osc_wrap = (8'(osc_cnt_ff + 8'h01) >= osc_div_ff);
   assign int_tick = pin_s.sel & ~pdown_ff & osc_wrap & ~osc_ff;

   always_ff @(posedge mclk)
   begin
      if (hw_clr)
      begin
         osc_cnt_ff <= '0;
         osc_ff <= 1'b0;
      end
      else if (pin_s.sel && !pdown_ff)
      begin
         if (osc_wrap)
         begin
            osc_cnt_ff <= '0;
            osc_ff <= ~osc_ff;
         end
         else
            osc_cnt_ff <= 8'(osc_cnt_ff + 8'h01);
      end
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
         oe_ff <= 1'b0;
      else
         oe_ff <= pin_s.sel;
   end

   assign mux_tick = (pin_s.sel ? int_tick : ext_tick) & ~pdown_ff;

   // Soft clear does not reach this counter.
   always_ff @(posedge mclk)
   begin
      if (hw_clr)
      begin
         phase_ff <= '0;
         row_ff <= '0;
      end
      else if (mux_tick)
      begin
         if (phase_ff == MUX_LAST)
         begin
            phase_ff <= '0;
            row_ff <= (row_ff == ROW_LAST) ? 3'h0 : 3'(row_ff + 3'h1);
         end
         else
            phase_ff <= 9'(phase_ff + 9'h001);
      end
   end

   // RAM read data lags the row counter by one cycle; the strobe follows.
   assign duty_now = DUTY_TBL[lamp_ff ? LEVEL_LAMP : level_ff];
   assign strobe_on = ~pdown_ff & ~clear_active_ff
                      & (phase_ff < duty_now);

   always_ff @(posedge mclk)
   begin
      if (hw_clr)
      begin
         row_d_ff <= '0;
         row_strobe_ff <= '0;
         col_drive_ff <= '0;
      end
      else
      begin
         row_d_ff <= row_ff;
         row_strobe_ff <= strobe_on ? 5'(ROW_ONE << row_d_ff) : 5'h00;
         col_drive_ff <= lamp_ff ? ALL_COLS : ram_rd;
      end
   end

   assign row_strobe = row_strobe_ff;
   assign col_drive = col_drive_ff;
   assign row_multiplex_clock_out = osc_ff;
   assign row_multiplex_clock_oe = oe_ff;

   assign stat = '{zero: '0, row: row_ff, clr: clear_active_ff,
                   pdown: pdown_ff, lamp: lamp_ff, level: level_ff,
                   addr: addr_ff};

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end
      else
      begin
         wb_ack_o <= wb_req & ~(bus_cmd & load_rise);
         case (wb_adr_i)
            REG_CMD: wb_dat_o <= {24'h000000, last_word_ff};
            REG_STAT: wb_dat_o <= stat;
            REG_OSC: wb_dat_o <= {24'h000000, osc_div_ff};
            default: wb_dat_o <= '0;
         endcase
      end
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
         osc_div_ff <= OSC_HALF_RST;
      else if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == REG_OSC)
         osc_div_ff <= wb_dat_i[7:0];
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (srst);

   sequence s_clear;
      is_clear && !hw_clr;
   endsequence

   a_load_decode: assert property (load_rise && !hw_clr |=>
      last_word_ff == $past(shift_ff))
      else $error("Loaded word not decoded from shift register.");
   a_addr_load: assert property (is_addr && !hw_clr |=>
      addr_ff == last_word_ff.pl[3:0])
      else $error("Character address not loaded.");
   a_level_set: assert property (is_level && !hw_clr |=>
      level_ff == last_word_ff.pl[2:0] && !lamp_ff && !pdown_ff)
      else $error("Brightness word did not take effect.");
   a_duty_bound: assert property ((|row_strobe_ff) |->
      $past(phase_ff) < $past(duty_now) && !$past(pdown_ff))
      else $error("Row strobe outside its duty window.");
   a_pdown_dark: assert property (pdown_ff && !hw_clr |=>
      row_strobe_ff == 5'h00 && $stable(phase_ff))
      else $error("Display not dark or counter running in power-down.");
   a_lamp_cols: assert property (lamp_ff && !hw_clr |=>
      col_drive_ff == ALL_COLS)
      else $error("Lamp test not lighting every column.");
   a_clear_addr: assert property (s_clear |=>
      addr_ff == 4'h0 && clear_active_ff ##1 row_strobe_ff == 5'h00)
      else $error("Software clear did not reset address or blank.");
   a_clear_keeps: assert property (s_clear |=>
      $stable(level_ff) && $stable(pdown_ff) && $stable(lamp_ff))
      else $error("Software clear changed control settings.");
   a_clear_hold: assert property (clear_active_ff && !load_fall && !bus_go
      && !hw_clr |=> clear_active_ff)
      else $error("Clear ended before next input cycle.");
   a_row_advance: assert property (mux_tick && phase_ff == MUX_LAST
      && !hw_clr |=> row_ff != $past(row_ff) && phase_ff == 9'h000)
      else $error("Row did not advance after 320 ticks.");
   a_pin_reset: assert property (!pin_s.rst_n |=> addr_ff == 4'h0
      && level_ff == LEVEL_FULL && row_strobe_ff == 5'h00)
      else $error("Reset pin did not clear state.");
   a_ignore_cmd: assert property (exec && !known && !hw_clr |=>
      $stable(addr_ff) && $stable(level_ff) && $stable(pdown_ff)
      && $stable(lamp_ff))
      else $error("Unlisted word changed stored state.");
endmodule // serial_dot_matrix_display_ctrl

// *** host_serial_model.sv ***
// Host side of the serial link: shifts command words into the display.
// Assumes mclk at 25 MHz; sck stays high four mclk cycles and low five between bits.
`timescale 1ns/100ps
module host_serial_model (
   // Clock.
   input wire logic mclk,
   // Serial pins toward the display.
   output logic sck,
   output logic sdata,
   output logic load_n
);
   logic busy;

   initial
   begin
      sck = 1'b0;
      sdata = 1'b0;
      load_n = 1'b1;
      busy = 1'b0;
   end

   // An idle data line keeps moving so a stale bit can never pass as valid.
   always @(posedge mclk)
      if (!busy)
         sdata <= ~sdata;

   task automatic send_word(input logic [7:0] w);
      int i;
      busy = 1'b1;
      @(posedge mclk);
      load_n <= 1'b0;
      for (i = 0; i < 8; i++)
      begin
         @(posedge mclk);
         sdata <= w[i];
         repeat (4) @(posedge mclk);
         sck <= 1'b1;
         repeat (4) @(posedge mclk);
         sck <= 1'b0;
      end
      repeat (4) @(posedge mclk);
      load_n <= 1'b1;
      // Fifteen cycles is 600 ns, long enough for the word to take effect.
      repeat (15) @(posedge mclk);
      busy = 1'b0;
   endtask
endmodule // host_serial_model

// *** serial_dot_matrix_display_ctrl_tb.sv ***
// Self-checking bench: host model on the serial pins, Wishbone reads of STAT.
// Assumes the OSC register set to 1, so one row lasts 640 mclk cycles.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
   n_mismatch++; $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module serial_dot_matrix_display_ctrl_tb;
   import disp_pkg::*;
   typedef struct packed { logic [31:0] m; logic [31:0] v; } note_t;
   logic mclk, srst, sel_pin, ext_clk, rst_pin, ext_en, cyc, stb, we;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] dat, wb_dat_o;
   logic [31:0] rs = 32'h0000000D;
   logic wb_ack_o, clk_out, clk_oe, sck, sdata, load_n;
   logic [NUM_ROWS-1:0] row_strobe;
   logic [COL_BITS-1:0] col_drive;
   int n_mismatch = 0, tests_run = 0, ext_cnt_ff = 0, i, j, c, r, on, per, n;
   int on_t[7] = '{320, 170, 128, 86, 64, 42, 21};
   note_t exp_q[$], nt;

   always #20 mclk = ~mclk;

   host_serial_model host (.mclk(mclk), .sck(sck), .sdata(sdata),
      .load_n(load_n));
   serial_dot_matrix_display_ctrl uut (.mclk(mclk), .srst(srst),
      .serial_shift_clock(sck), .serial_data(sdata), .load_n(load_n),
      .display_reset_n(rst_pin), .row_multiplex_clock_source_select(sel_pin),
      .row_multiplex_clock_in(ext_clk), .row_multiplex_clock_out(clk_out),
      .row_multiplex_clock_oe(clk_oe), .row_strobe(row_strobe),
      .col_drive(col_drive), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o));

   // External multiplex clock: 25 mclk cycles per period is 1.0 MHz.
   always @(posedge mclk)
   begin
      ext_cnt_ff <= (ext_cnt_ff == 24) ? 0 : ext_cnt_ff + 1;
      ext_clk <= ext_en && (ext_cnt_ff < 12);
   end

   function automatic logic [31:0] xs();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic wb_acc(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [3:0] s, input logic [31:0] m,
      input logic [31:0] e);
      int k;
      exp_q.push_back('{m, e});
      @(posedge mclk);
      {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, s};
      for (k = 0; k < 50; k++)
      begin
         @(posedge mclk);
         if (wb_ack_o === 1'b1)
            break;
      end
      {cyc, stb, we} <= 3'b000;
      if (k == 50)
         n_mismatch++;
      @(posedge mclk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
      wb_acc(1'b0, a, 32'h0, 4'hF, m, e);
   endtask

   // The monitor takes the oldest note whenever an answer appears.
   always @(posedge mclk)
      if (wb_ack_o === 1'b1)
      begin
         nt = exp_q.pop_front();
         if (nt.m != 0)
            `CHK("wb_dat_o", nt.v, wb_dat_o & nt.m)
      end

   task automatic wait_lvl(input logic want, output int cnt);
      for (cnt = 0; cnt < 20000; cnt++)
      begin
         @(negedge mclk);
         if ((row_strobe != 0) == want)
            break;
      end
      if (cnt == 20000)
         n_mismatch++;
   endtask

   // The first pulse after a change may be partial, so it is skipped.
   task automatic meas(output int on_c, output int per_c);
      int k;
      wait_lvl(1'b0, k);
      wait_lvl(1'b1, k);
      wait_lvl(1'b0, on_c);
      wait_lvl(1'b1, k);
      per_c = on_c + k;
   endtask

   task automatic wait_row(input int rw);
      int k;
      for (k = 0; k < 20000; k++)
      begin
         @(negedge mclk);
         if (row_strobe === (ROW_ONE << rw))
            break;
      end
      if (k == 20000)
         n_mismatch++;
   endtask

   initial
   begin
      repeat (95000) @(posedge mclk);
      n_mismatch++;
      report_and_stop();
   end

   initial
   begin
      {mclk, srst, sel_pin, rst_pin, ext_en, cyc, stb, we} = 8'h70;
      {adr, sel, dat} = 44'h0;
      repeat (3) @(posedge mclk);
      srst <= 1'b0;
      repeat (4) @(posedge mclk);
      rd(REG_STAT, 32'h3FF, 32'h0);
      rd(REG_OSC, 32'hFF, 32'h34);
      rd(8'h0C, 32'hFFFFFFFF, 32'h0);
      wb_acc(1'b1, REG_OSC, 32'h1, 4'h1, 32'h0, 32'h0);
      `CHK("clk_oe", 1'b1, clk_oe)
      host.send_word(8'hB5);
      rd(REG_STAT, 32'h3FF, 32'h005);
      rd(REG_CMD, 32'hFF, 32'hB5);
      host.send_word(8'hBA);
      host.send_word(8'hF7);
      rd(REG_STAT, 32'h3FF, 32'h005);
      wb_acc(1'b1, REG_CMD, 32'hB6, 4'h1, 32'h0, 32'h0);
      wb_acc(1'b1, REG_CMD, 32'hB9, 4'h0, 32'h0, 32'h0);
      rd(REG_STAT, 32'hF, 32'h6);
      for (i = 0; i < 7; i++)
      begin
         host.send_word(8'(8'hF0 + i));
         rd(REG_STAT, 32'h70, 32'(i) << 4);
         if (i > 0)
         begin
            meas(on, per);
            `CHK("on_time", 1'b1, on > 2*on_t[i]-4 && on < 2*on_t[i]+4)
            `CHK("row_period", 1'b1, per > 636 && per < 644)
         end
      end
      host.send_word(8'hF0);
      for (j = 0; j < 3; j++)
      begin
         rs = xs();
         c = rs % 10;
         r = (rs >> 8) % 5;
         host.send_word({4'hB, 4'(c)});
         host.send_word({3'(r), rs[20:16]});
         wait_row(r);
         `CHK("col_drive", rs[20:16], col_drive[5*c +: 5])
      end
      host.send_word(8'hFF);
      rd(REG_STAT, 32'h100, 32'h100);
      n = 0;
      c = 0;
      r = clk_out;
      repeat (700) @(negedge mclk)
      begin
         n += (row_strobe != 0);
         c += (clk_out != r);
         r = clk_out;
      end
      `CHK("dark_rows", 0, n)
      `CHK("osc_halt", 0, c)
      host.send_word(8'hB4);
      host.send_word(8'h55);
      host.send_word(8'hF0);
      rd(REG_STAT, 32'h100, 32'h0);
      @(negedge mclk) r = clk_out;
      @(negedge mclk) `CHK("osc_run", r == 0, clk_out)
      wait_row(2);
      `CHK("col_drive", 5'h15, col_drive[24:20])
      host.send_word(8'hF8);
      rd(REG_STAT, 32'h80, 32'h80);
      wait_lvl(1'b1, n);
      `CHK("lamp_cols", ALL_COLS, col_drive)
      meas(on, per);
      `CHK("lamp_on", 1'b1, on > 336 && on < 344)
      host.send_word(8'hF2);
      rd(REG_STAT, 32'hF0, 32'h20);
      wait_row(2);
      `CHK("col_drive", 5'h15, col_drive[24:20])
      host.send_word(8'hB7);
      host.send_word(8'hF3);
      host.send_word(8'hC0);
      rd(REG_STAT, 32'h3FF, 32'h230);
      n = 0;
      repeat (700) @(negedge mclk) n += (col_drive != 0);
      `CHK("blank_cols", 0, n)
      host.send_word(8'hB2);
      rd(REG_STAT, 32'h3FF, 32'h032);
      wait_row(2);
      `CHK("col_drive", 5'h00, col_drive[24:20])
      host.send_word(8'hF1);
      @(posedge mclk);
      {sel_pin, ext_en} <= 2'b01;
      repeat (10) @(negedge mclk);
      `CHK("clk_oe", 1'b0, clk_oe)
      meas(on, per);
      `CHK("ext_period", 1'b1, per > 7970 && per < 8030)
      @(posedge mclk);
      {sel_pin, ext_en} <= 2'b10;
      rst_pin <= 1'b0;
      repeat (6) @(negedge mclk);
      `CHK("rst_rows", 5'h00, row_strobe)
      `CHK("rst_cols", 50'h0, col_drive)
      @(posedge mclk);
      rst_pin <= 1'b1;
      repeat (4) @(posedge mclk);
      rd(REG_STAT, 32'h3FF, 32'h0);
      report_and_stop();
   end
endmodule // serial_dot_matrix_display_ctrl_tb
